// ===== verilog/chd_consts.vh
// Constants for the associative memory host cycle decoder
`ifndef CHD_CONSTS_VH
`define CHD_CONSTS_VH
// ****************************************
// Array geometry
// ****************************************
`define CHD_DEPTH 1024
`define CHD_AW 10
`define CHD_ALL_ONES16 16'hffff
// ****************************************
// Instruction fields (upper data lanes)
// ****************************************
`define CHD_F_BIT 11
`define CHD_OP_NOP 4'h0
`define CHD_OP_TCO 4'h1
`define CHD_OP_SPS 4'h2
`define CHD_OP_SPD 4'h3
`define CHD_OP_SFR 4'h4
`define CHD_OP_SBR 4'h5
`define CHD_OP_RSC 4'h6
// Override targets
`define CHD_T_CT 3'h0
`define CHD_T_PA 3'h1
`define CHD_T_SC 3'h2
`define CHD_T_AR 3'h3
`define CHD_T_NF 3'h4
`define CHD_T_DS 3'h5
`define CHD_T_PS 3'h6
`define CHD_T_PD 3'h7
// Persistent source and destination codes
`define CHD_R_CR 3'h0
`define CHD_R_MR1 3'h1
`define CHD_R_MR2 3'h2
`define CHD_R_MAR 3'h3
`define CHD_R_MNF 3'h4
`define CHD_R_MHP 3'h5
// ****************************************
// Control register fields and reset
// ****************************************
`define CHD_CT_RST 16'h0008
`define CHD_CT_RSTBIT 15
`define CHD_MASK_MR1 2'h1
`define CHD_MASK_MR2 2'h2
`define CHD_INC_UP 2'h0
`define CHD_INC_DN 2'h1
// ****************************************
// Segment control layout and reset
// ****************************************
`define CHD_SC_RST 16'h0c0c
`define CHD_DEV_ID 16'h5a01
`endif

// ===== verilog/chd_cam_host_cycle_decoder.v
// Host cycle decoder and register sets of a 128-bit associative memory
`include "chd_consts.vh"

module chd_cam_host_cycle_decoder (
	input wire mclk, // System clock
	input wire resetn, // Async reset, active low
	input wire chip_enable_n, // Cycle strobe pin
	input wire write_n, // Low for input cycles
	input wire command_select_n, // Low for command cycles
	input wire [31:0] dq_in, // Data lanes in
	output reg [31:0] dq_out, // Data lanes out
	output reg dq_oe, // High while driving lanes
	output reg match_n, // Low when compare hit
	output reg multi_match_n, // Low when several hits
	output reg full_n // Low when array full
);

	// ****************************************
	// Pin synchronisers and filters
	// ****************************************
	reg [2:0] e_s, w_s, c_s;
	reg [31:0] d1, d2, d3, d_f;
	reg e_f, w_f, c_f, e_d;
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			e_s <= 3'h7;
			w_s <= 3'h7;
			c_s <= 3'h7;
			e_f <= 1'b1;
			w_f <= 1'b1;
			c_f <= 1'b1;
			e_d <= 1'b1;
			d1 <= 32'h0;
			d2 <= 32'h0;
			d3 <= 32'h0;
			d_f <= 32'h0;
		end else begin
			e_s <= {e_s[1:0], chip_enable_n};
			w_s <= {w_s[1:0], write_n};
			c_s <= {c_s[1:0], command_select_n};
			d1 <= dq_in;
			d2 <= d1;
			d3 <= d2;
			if (e_s[1] == e_s[2]) e_f <= e_s[2];
			if (w_s[1] == w_s[2]) w_f <= w_s[2];
			if (c_s[1] == c_s[2]) c_f <= c_s[2];
			d_f <= (d2 & ~(d2 ^ d3)) | (d_f & (d2 ^ d3));
			e_d <= e_f;
		end
	end

	// ****************************************
	// State
	// ****************************************
	reg bk;
	reg [15:0] ctrl [0:1];
	reg [15:0] segc [0:1];
	reg [15:0] ar [0:1];
	reg [127:0] mr1 [0:1];
	reg [15:0] psi [0:1];
	reg [15:0] pdi [0:1];
	reg [127:0] cr, mr2;
	reg [127:0] mem [0:`CHD_DEPTH-1];
	reg [`CHD_DEPTH-1:0] skp, emp;
	reg [15:0] pa, ds, nf;
	reg pend;
	reg [2:0] pend_t;
	reg adv_d, adv_s, cmp_go;
	reg [`CHD_AW-1:0] st_hpm;
	integer i;

	// ****************************************
	// Cycle decode
	// ****************************************
	wire fall = e_d & ~e_f;
	wire rise = ~e_d & e_f;
	wire wr = ~w_f;
	wire cmd = ~c_f;
	wire [15:0] ins = d_f[31:16];
	wire [3:0] op = ins[15:12];
	wire fbit = ins[`CHD_F_BIT];
	wire [2:0] tsel = ins[2:0];
	wire [15:0] ct = ctrl[bk];
	wire [15:0] sc = segc[bk];
	wire [1:0] dcur = sc[1:0];
	wire [1:0] dend = sc[3:2];
	wire [1:0] dst = sc[5:4];
	wire [1:0] scur = sc[9:8];
	wire [1:0] send = sc[11:10];
	wire [1:0] sst = sc[13:12];
	wire [2:0] pdc = pdi[bk][2:0];
	wire [2:0] psc = psi[bk][2:0];
	wire hpm_ok = ~match_n & (ct[14:13] == 2'h0);
	wire nf_ok = (ct[12:11] == 2'h0) & full_n;
	// Always-accepted select write
	// select always taken
	wire ds_wr = cmd & wr & (op == `CHD_OP_TCO) & fbit & (tsel == `CHD_T_DS);
	wire sel_ok = (ds == pa) | ((ds == `CHD_ALL_ONES16) & (wr | ~match_n));
	wire go = fall & (sel_ok | ds_wr);
	wire dwr = go & ~cmd & wr;
	wire drd = go & ~cmd & ~wr;
	wire cwr = go & cmd & wr;
	wire crd = go & cmd & ~wr;

	// ****************************************
	// Compare and priority search
	// ****************************************
	reg [127:0] cmsk;
	reg hit, multi, freef;
	reg [`CHD_AW-1:0] hpm_i, nf_i;
	always @* begin
		cmsk = 128'h0;
		if (ct[5:4] == `CHD_MASK_MR1) cmsk = mr1[bk];
		if (ct[5:4] == `CHD_MASK_MR2) cmsk = mr2;
		for (i = 0; i < 4; i = i + 1) begin
			if (ct[8] ? (i < ct[7:6]) : (i >= 4 - ct[7:6])) cmsk[i*32 +: 32] = 32'hffffffff;
		end
		hit = 1'b0;
		multi = 1'b0;
		freef = 1'b0;
		hpm_i = {`CHD_AW{1'b0}};
		nf_i = {`CHD_AW{1'b0}};
		for (i = `CHD_DEPTH - 1; i >= 0; i = i - 1) begin
			if (~skp[i] & ~emp[i] & (((mem[i] ^ cr) & ~cmsk) == 128'h0)) begin
				multi = hit;
				hit = 1'b1;
				hpm_i = i[`CHD_AW-1:0];
			end
			if (~skp[i] & emp[i]) begin
				freef = 1'b1;
				nf_i = i[`CHD_AW-1:0];
			end
		end
	end

	// Status word layout
	wire [31:0] status = {match_n, multi_match_n, full_n, 3'h0, st_hpm, pa};

	// ****************************************
	// Memory write path
	// ****************************************
	reg mem_we;
	reg [`CHD_AW-1:0] mem_wa;
	always @* begin
		mem_we = 1'b0;
		mem_wa = ar[bk][`CHD_AW-1:0];
		if (dwr) begin
			case (pdc)
				`CHD_R_MAR: mem_we = 1'b1;
				`CHD_R_MNF: begin
					mem_we = nf_ok;
					mem_wa = nf[`CHD_AW-1:0];
				end
				`CHD_R_MHP: begin
					mem_we = hpm_ok;
					mem_wa = st_hpm;
				end
				default: mem_we = 1'b0;
			endcase
		end
	end
	always @(posedge mclk) begin
		if (mem_we) mem[mem_wa][{dcur, 5'h0} +: 32] <= d_f;
	end

	// Read data source
	reg [127:0] src;
	reg src_ok;
	always @* begin
		src_ok = 1'b1;
		case (psc)
			`CHD_R_MR1: src = mr1[bk];
			`CHD_R_MR2: src = mr2;
			`CHD_R_MAR: src = mem[ar[bk][`CHD_AW-1:0]];
			`CHD_R_MHP: begin
				src = mem[st_hpm];
				src_ok = hpm_ok;
			end
			default: src = cr;
		endcase
	end

	// Override readback word
	reg [31:0] tco_rd;
	always @* begin
		tco_rd = {status[31:16], 16'h0};
		case (pend_t)
			`CHD_T_CT: tco_rd[15:0] = {1'b0, ct[14:0]};
			`CHD_T_PA: tco_rd = {16'h0, pa};
			`CHD_T_SC: tco_rd[15:0] = sc;
			`CHD_T_AR: tco_rd[15:0] = ar[bk];
			`CHD_T_NF: tco_rd[15:0] = nf;
			`CHD_T_DS: tco_rd[15:0] = ds;
			`CHD_T_PS: tco_rd = {`CHD_DEV_ID, psi[bk]};
			default: tco_rd[15:0] = pdi[bk];
		endcase
	end

	// Address register stepping
	function [15:0] step;
		input [15:0] a;
		input [1:0] m;
		begin
			step = (m == `CHD_INC_UP) ? a + 16'h1 : (m == `CHD_INC_DN) ? a - 16'h1 : a;
		end
	endfunction

	// ****************************************
	// Configuration reset, shared by both resets
	// ****************************************
	task init_cfg;
		integer k;
		begin
			bk <= 1'b0;
			for (k = 0; k < 2; k = k + 1) begin
				ctrl[k] <= `CHD_CT_RST;
				segc[k] <= `CHD_SC_RST;
				ar[k] <= 16'h0;
				mr1[k] <= 128'h0;
				psi[k] <= 16'h0;
				pdi[k] <= 16'h0;
			end
			cr <= 128'h0;
			mr2 <= 128'h0;
			nf <= 16'h0;
			skp <= {`CHD_DEPTH{1'b0}};
			emp <= {`CHD_DEPTH{1'b1}};
			pend <= 1'b0;
			pend_t <= 3'h0;
			adv_d <= 1'b0;
			adv_s <= 1'b0;
			cmp_go <= 1'b0;
			st_hpm <= {`CHD_AW{1'b0}};
			match_n <= 1'b1;
			multi_match_n <= 1'b1;
		end
	endtask

	// ****************************************
	// Main cycle engine
	// ****************************************
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			init_cfg;
			pa <= 16'h0;
			ds <= 16'h0;
			dq_out <= 32'h0;
			dq_oe <= 1'b0;
			full_n <= 1'b1;
		end else if (cwr & (op == `CHD_OP_TCO) & fbit & (tsel == `CHD_T_CT) & ~d_f[`CHD_CT_RSTBIT]) begin
			// software reset; keeps page and select
			init_cfg;
		end else begin
			full_n <= freef;
			cmp_go <= 1'b0;
			if (cmp_go) begin
				match_n <= ~hit;
				multi_match_n <= ~multi;
				st_hpm <= hpm_i;
				if (nf_ok) nf <= {{(16-`CHD_AW){1'b0}}, nf_i};
			end
			if (go) pend <= 1'b0;
			if (cwr) begin
				if (fbit & (op != `CHD_OP_TCO)) ar[bk] <= d_f[15:0];
				case (op)
					`CHD_OP_TCO: begin
						if (!fbit) begin
							pend <= 1'b1;
							pend_t <= tsel;
						end else begin
							case (tsel)
								`CHD_T_CT: begin
									ctrl[bk] <= {1'b0, d_f[14:0]};
									cmp_go <= 1'b1;
								end
								`CHD_T_PA: if (ct[12:11] == 2'h0) pa <= d_f[15:0];
								`CHD_T_SC: segc[bk] <= d_f[15:0];
								`CHD_T_AR: ar[bk] <= d_f[15:0];
								`CHD_T_DS: ds <= d_f[15:0];
								default: pend <= 1'b0;
							endcase
						end
					end
					`CHD_OP_SPS: psi[bk] <= ins;
					`CHD_OP_SPD: pdi[bk] <= ins;
					`CHD_OP_SFR: bk <= 1'b0;
					`CHD_OP_SBR: bk <= 1'b1;
					`CHD_OP_RSC: segc[bk] <= {sc[15:10], sst, sc[7:2], dst};
					default: pend <= 1'b0;
				endcase
			end
			if (dwr) begin
				adv_d <= 1'b1;
				case (pdc)
					`CHD_R_CR: cr[{dcur, 5'h0} +: 32] <= d_f;
					`CHD_R_MR1: mr1[bk][{dcur, 5'h0} +: 32] <= d_f;
					`CHD_R_MR2: mr2[{dcur, 5'h0} +: 32] <= d_f;
					default: adv_d <= 1'b1;
				endcase
				if ((dcur == dend) & (pdc <= `CHD_R_MR2)) cmp_go <= 1'b1;
				if (mem_we & (dcur == dend)) begin
					emp[mem_wa] <= 1'b0;
					skp[mem_wa] <= 1'b0;
					if (pdc == `CHD_R_MAR) ar[bk] <= step(ar[bk], ct[3:2]);
				end
			end
			if (drd & src_ok) begin
				dq_out <= src[{scur, 5'h0} +: 32];
				dq_oe <= 1'b1;
				adv_s <= 1'b1;
				if ((scur == send) & (psc == `CHD_R_MAR)) ar[bk] <= step(ar[bk], ct[3:2]);
			end
			if (crd) begin
				dq_out <= pend ? tco_rd : status;
				dq_oe <= 1'b1;
			end
			if (rise) begin
				dq_oe <= 1'b0;
				adv_d <= 1'b0;
				adv_s <= 1'b0;
				if (adv_d) segc[bk][1:0] <= (dcur == dend) ? dst : dcur + 2'h1;
				if (adv_s) segc[bk][9:8] <= (scur == send) ? sst : scur + 2'h1;
			end
		end
	end

endmodule

// ===== test/chd_cam_host_cycle_decoder_sva.sv
// Port checker for the host cycle decoder
module chd_cam_host_cycle_decoder_sva (
	input wire logic mclk, // System clock
	input wire logic resetn, // Async reset, active low
	input wire logic chip_enable_n, // Cycle strobe pin
	input wire logic write_n, // Low for input cycles
	input wire logic command_select_n, // Low for command cycles
	input wire logic [31:0] dq_in, // Lanes in
	input wire logic [31:0] dq_out, // Lanes out
	input wire logic dq_oe, // Lane drive enable
	input wire logic match_n, // Compare hit
	input wire logic multi_match_n, // Several hits
	input wire logic full_n // Array full
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] idle_q;
	// Clocks since the strobe was last low, saturating
	always @(posedge mclk or negedge resetn) begin
		if (!resetn)
			idle_q <= 4'hf;
		else if (!chip_enable_n)
			idle_q <= 4'h0;
		else if (idle_q != 4'hf)
			idle_q <= idle_q + 4'h1;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	// ****************************************
	// Strobe phases
	// ****************************************
	sequence s_idle;
		chip_enable_n [*6];
	endsequence
	sequence s_write;
		(!chip_enable_n && !write_n) [*4];
	endsequence
	// ****************************************
	// Assertions
	// ****************************************
	a_idle_quiet: assert property (s_idle |-> !dq_oe)
		else $error("lanes driven while idle");
	a_write_quiet: assert property (s_write |-> !dq_oe)
		else $error("lanes driven in write cycle");
	a_drive_cause: assert property ($rose(dq_oe) |-> write_n && !chip_enable_n)
		else $error("drive started outside read");
	a_drive_hold: assert property (dq_oe && !chip_enable_n |=> dq_oe)
		else $error("drive dropped while strobe low");
	a_drive_release: assert property ($fell(dq_oe) |-> chip_enable_n)
		else $error("drive released while strobe low");
	a_read_stable: assert property (dq_oe && $past(dq_oe) |-> $stable(dq_out))
		else $error("read data moved while driven");
	a_multi_match: assert property (!multi_match_n |-> !match_n)
		else $error("multiple hit without hit");
	a_flag_cause: assert property ($changed(match_n) || $changed(multi_match_n) |-> idle_q < 4'h8)
		else $error("compare flags moved without a cycle");
	a_reset_flags: assert property ($rose(resetn) |-> match_n && multi_match_n && full_n && !dq_oe)
		else $error("flags wrong after reset");
endmodule

bind chd_cam_host_cycle_decoder chd_cam_host_cycle_decoder_sva chk_i (.mclk(mclk), .resetn(resetn),
	.chip_enable_n(chip_enable_n), .write_n(write_n), .command_select_n(command_select_n), .dq_in(dq_in),
	.dq_out(dq_out), .dq_oe(dq_oe), .match_n(match_n), .multi_match_n(multi_match_n), .full_n(full_n));

// ===== test/chd_host_model.sv
// Host processor model driving the strobes and data lanes
module chd_host_model (
	input wire logic mclk, // System clock
	output logic chip_enable_n, // Cycle strobe
	output logic write_n, // Low for writes
	output logic command_select_n, // Low for commands
	output logic [31:0] dq_in, // Lanes to device
	input wire logic [31:0] dq_out, // Lanes from device
	input wire logic dq_oe // Device drives lanes
);
	timeunit 1ns;
	timeprecision 1ps;
	// Bus idle at time zero
	initial begin
		chip_enable_n = 1'b1;
		write_n = 1'b1;
		command_select_n = 1'b1;
		dq_in = 32'h0;
	end
	// flag set to load, clear to read back
	function automatic logic [31:0] ins(input logic [3:0] op, input logic f, input logic [2:0] t,
		input logic [15:0] v);
		ins = {op, f, 8'h00, t, v};
	endfunction
	// One strobe cycle, four clocks of setup, eight low, six high
	task automatic cyc(input logic cmd_n, input logic wr_n, input logic [31:0] d, output logic [31:0] q,
		output logic oe);
		@(negedge mclk);
		command_select_n = cmd_n;
		write_n = wr_n;
		// Released lanes show the inverse, never the last value
		dq_in = wr_n ? ~dq_in : d;
		repeat (4) @(negedge mclk);
		chip_enable_n = 1'b0;
		repeat (8) @(negedge mclk);
		q = dq_out;
		oe = dq_oe;
		chip_enable_n = 1'b1;
		repeat (6) @(negedge mclk);
	endtask
endmodule

// ===== test/chd_cam_host_cycle_decoder_tb.sv
// Self-checking bench for the host cycle decoder
`include "chd_consts.vh"
module chd_cam_host_cycle_decoder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic chip_enable_n, write_n, command_select_n, dq_oe, match_n, multi_match_n, full_n, oe;
	logic [31:0] dq_in, dq_out, q;
	int bad_count = 0;
	int n_compared = 0;
	int cyc_n = 0;
	logic [31:0] pat [4] = '{32'ha5a50000, 32'h3c3c1111, 32'h0ff02222, 32'h96693333};
	logic [31:0] rst_exp [6] = '{32'he0000008, 32'h0, 32'he0000c0c, 32'he0000000, 32'he0000000, 32'he0000000};
	logic [2:0] src [3] = '{`CHD_R_CR, `CHD_R_MAR, `CHD_R_MHP};
	initial forever #4 mclk = ~mclk;
	chd_cam_host_cycle_decoder uut (.mclk(mclk), .resetn(resetn), .chip_enable_n(chip_enable_n),
		.write_n(write_n), .command_select_n(command_select_n), .dq_in(dq_in), .dq_out(dq_out),
		.dq_oe(dq_oe), .match_n(match_n), .multi_match_n(multi_match_n), .full_n(full_n));
	chd_host_model host (.mclk(mclk), .chip_enable_n(chip_enable_n), .write_n(write_n),
		.command_select_n(command_select_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [3:0] op, input logic f, input logic [2:0] t, input logic [15:0] v);
		host.cyc(1'b0, 1'b0, host.ins(op, f, t, v), q, oe);
	endtask
	// Override readback: command write, then command read
	task automatic rreg(input logic [2:0] t, input logic [31:0] exp, input logic [31:0] m = 32'hffffffff);
		cmd(`CHD_OP_TCO, 1'b0, t, 16'h0);
		host.cyc(1'b0, 1'b1, 32'h0, q, oe);
		chk(q & m, exp);
	endtask
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Hang guard
	always @(posedge mclk) begin
		cyc_n++;
		if (cyc_n == 3000) begin
			bad_count++;
			test_done();
		end
	end
	// Main sequence
	initial begin
		repeat (5) @(negedge mclk);
		resetn = 1'b1;
		repeat (4) @(negedge mclk);
		host.cyc(1'b0, 1'b1, 32'h0, q, oe);
		chk(q, 32'he0000000);
		for (int t = 0; t < 6; t++)
			rreg(3'(t), rst_exp[t]);
		$display("test reset values done");
		cmd(`CHD_OP_TCO, 1'b1, `CHD_T_AR, 16'h0005);
		cmd(`CHD_OP_SBR, 1'b0, 3'h0, 16'h0);
		rreg(`CHD_T_AR, 32'he0000000);
		cmd(`CHD_OP_TCO, 1'b1, `CHD_T_AR, 16'h0007);
		cmd(`CHD_OP_SFR, 1'b0, 3'h0, 16'h0);
		rreg(`CHD_T_AR, 32'he0000005);
		$display("test register sets done");
		cmd(`CHD_OP_SPD, 1'b0, `CHD_R_MAR, 16'h0);
		foreach (pat[i]) host.cyc(1'b1, 1'b0, pat[i], q, oe);
		chk({31'h0, match_n}, 32'h1);
		cmd(`CHD_OP_SPD, 1'b0, `CHD_R_CR, 16'h0);
		foreach (pat[i]) host.cyc(1'b1, 1'b0, pat[i], q, oe);
		chk({31'h0, match_n}, 32'h0);
		host.cyc(1'b0, 1'b1, 32'h0, q, oe);
		chk(q, 32'h60050000);
		foreach (src[j]) begin
			cmd(`CHD_OP_SPS, 1'b0, src[j], 16'h0);
			foreach (pat[i]) begin
				host.cyc(1'b1, 1'b1, 32'h0, q, oe);
				chk(q, pat[i]);
			end
		end
		$display("test data path done");
		cmd(`CHD_OP_TCO, 1'b1, `CHD_T_DS, 16'h0003);
		host.cyc(1'b0, 1'b1, 32'h0, q, oe);
		chk({31'h0, oe}, 32'h0);
		cmd(`CHD_OP_TCO, 1'b1, `CHD_T_AR, 16'h0009);
		cmd(`CHD_OP_TCO, 1'b1, `CHD_T_DS, 16'h0000);
		rreg(`CHD_T_AR, 32'h60050005);
		$display("test deselect done");
		cmd(`CHD_OP_TCO, 1'b1, `CHD_T_PA, 16'h0002);
		cmd(`CHD_OP_TCO, 1'b1, `CHD_T_DS, 16'h0002);
		cmd(`CHD_OP_TCO, 1'b1, `CHD_T_CT, 16'h0000);
		rreg(`CHD_T_PA, 32'h00000002);
		rreg(`CHD_T_DS, 32'he0000002, 32'hfc00ffff);
		rreg(`CHD_T_AR, 32'he0000000, 32'hfc00ffff);
		rreg(`CHD_T_SC, 32'he0000c0c, 32'hfc00ffff);
		cmd(`CHD_OP_TCO, 1'b1, `CHD_T_CT, 16'h8008);
		rreg(`CHD_T_CT, 32'he0000008, 32'hfc00ffff);
		// Old word at address 5 must no longer take part once marked empty
		foreach (pat[i]) host.cyc(1'b1, 1'b0, pat[i], q, oe);
		chk({31'h0, match_n}, 32'h1);
		$display("test software reset done");
		// Hardware reset in mid-run clears page and select
		resetn = 1'b0;
		repeat (5) @(negedge mclk);
		resetn = 1'b1;
		repeat (4) @(negedge mclk);
		rreg(`CHD_T_PA, 32'h00000000);
		rreg(`CHD_T_DS, 32'he0000000);
		$display("test hardware reset done");
		test_done();
	end
endmodule
